// ---- pdp_pkg.sv ----
// constants and types shared by the playback path
package pdp_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_VOL = 8'h04;
   localparam logic [7:0] ADDR_TIME = 8'h08;
   localparam logic [7:0] ADDR_KNEE = 8'h0c;
   localparam logic [7:0] ADDR_SLOPE = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   // control field positions
   localparam int C_OSR = 0;
   localparam int C_INV = 2;
   localparam int C_MUTE_L = 3;
   localparam int C_MUTE_R = 4;
   localparam int C_SOFT = 5;
   localparam int C_AUTO = 6;
   localparam int C_MAN = 7;
   localparam int C_RINT = 8;
   localparam int C_CEN = 10;
   localparam int C_ALAW = 11;
   localparam int C_SMOOTH = 12;
   localparam int C_MIX_L = 16;
   localparam int C_MIX_R = 20;
   // volume, time, knee and slope field positions
   localparam int V_L = 0;
   localparam int V_R = 8;
   localparam int V_HP = 16;
   localparam int T_PKA = 0;
   localparam int T_PKD = 4;
   localparam int T_GA = 8;
   localparam int T_GD = 12;
   localparam int K_LIM = 0;
   localparam int K_C1 = 5;
   localparam int K_C2 = 10;
   localparam int K_STR = 16;
   localparam int K_GATE = 22;
   localparam int S_LIM = 0;
   localparam int S_C1 = 3;
   localparam int S_C2 = 6;
   localparam int S_STR = 9;
   localparam int S_GATE = 11;
   // reset values: 256x, straight mix, 0 dB, flat curve
   localparam logic [31:0] CTRL_RST = 32'h0021_0003;
   localparam logic [31:0] VOL_RST = 32'h0000_cfcf;
   localparam logic [31:0] TIME_RST = 32'h0000_0000;
   localparam logic [31:0] KNEE_RST = 32'h0000_0000;
   localparam logic [31:0] SLOPE_RST = 32'h0000_016f;
   // knee offsets of the low-level sections, in dB
   localparam logic [7:0] STR_KNEE0 = 8'h12;
   localparam logic [7:0] GATE_KNEE0 = 8'h23;
   // sample-count timing
   localparam logic [10:0] ZERO_RUN = 11'h400;
   localparam logic [7:0] ATT_STEP = 8'h80;
   localparam logic [5:0] ATT_MAX = 6'h36;
   // attenuation ramp states, gray along the path
   typedef enum logic [1:0] {
      ATT_IDLE = 2'b00,
      ATT_DOWN = 2'b01,
      ATT_HOLD = 2'b11,
      ATT_UP = 2'b10
   } pdp_att_t;
endpackage

// ---- pdp_playback_path.sv ----
// playback digital path with register slave
`timescale 1ns/10ps
`default_nettype none
module pdp_playback_path
   import pdp_pkg::*;
#(
   parameter int SW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_strobe,
   input wire logic [SW-1:0] left_playback_channel,
   input wire logic [SW-1:0] right_playback_channel,
   input wire logic [23:0] capture_left,
   input wire logic [23:0] capture_right,
   output logic [23:0] out_left,
   output logic [23:0] out_right,
   output logic out_valid,
   output logic [7:0] comp_code,
   output logic [1:0] osr_sel,
   output logic [7:0] hp_gain
);
   // software registers
   logic [31:0] ctrl, vol, timing, knee, slope;
   logic aw_got, w_got; // address and data each held once taken
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   // processing state
   logic [7:0] vcur_l, vcur_r; // soft-mute ramped volume codes
   logic [22:0] peak; // shared peak magnitude estimate
   logic [6:0] g_cur, g_prev; // applied and last target reduction, dB
   logic [16:0] g_tick; // samples since last gain step
   logic [10:0] zrun; // consecutive zero samples
   pdp_att_t att;
   logic [7:0] saved; // driver volume held during ramp
   logic [5:0] depth; // dB of attenuation applied
   logic [7:0] a_tick; // samples since last ramp step

   // 0.5 dB mantissas within one 6 dB octave, x256
   function automatic logic [8:0] half_db(input logic [3:0] k);
      case (k)
         4'h0: half_db = 9'h100;
         4'h1: half_db = 9'h0f1;
         4'h2: half_db = 9'h0e4;
         4'h3: half_db = 9'h0d7;
         4'h4: half_db = 9'h0cb;
         4'h5: half_db = 9'h0c0;
         4'h6: half_db = 9'h0b5;
         4'h7: half_db = 9'h0ab;
         4'h8: half_db = 9'h0a1;
         4'h9: half_db = 9'h098;
         4'ha: half_db = 9'h090;
         default: half_db = 9'h088;
      endcase
   endfunction

   // clamp to 24-bit two's complement
   function automatic logic [23:0] sat24(input logic signed [35:0] v);
      if (v > 36'sh0007fffff) sat24 = 24'h7fffff;
      else if (v < -36'sh000800000) sat24 = 24'h800000;
      else sat24 = v[23:0];
   endfunction

   // code 1 is -103 dB, 255 is +24 dB, 0 is silence
   function automatic logic [23:0] vol_apply(input logic [23:0] x, input logic [7:0] c);
      logic [7:0] a;
      logic [4:0] sh;
      logic signed [35:0] p;
      a = 8'hff - c;
      sh = 5'(a / 8'd12);
      p = 36'(signed'(x)) * $signed({1'b0, half_db(4'(a % 8'd12))});
      p = p >>> (4 + sh); // x16 ahead gives the +24 dB top
      vol_apply = (c == 8'h00) ? 24'h0 : sat24(p);
   endfunction

   // count leading zeros of a magnitude
   function automatic logic [4:0] lzc(input logic [22:0] v);
      lzc = 5'd23;
      for (int i = 0; i < 23; i++) begin
         if (v[i]) lzc = 5'(22 - i);
      end
   endfunction

   // reduction above a knee for slope 1/2^code; 0 is flat, one is unity
   function automatic logic [7:0] red(input logic [7:0] d, input logic [2:0] c,
                                      input logic [2:0] one);
      if (c == 3'd0) red = d;
      else if (c >= one) red = 8'h0;
      else red = d - (d >> c);
   endfunction

   // extra loss below a knee for slope 2^code
   function automatic logic [9:0] stretch(input logic [7:0] e, input logic [1:0] c);
      stretch = ({2'b0, e} << c) - {2'b0, e};
   endfunction

   // 14-bit magnitude to mu-law, 255 law segments
   function automatic logic [7:0] mu_enc(input logic [23:0] s);
      logic [13:0] m;
      logic [2:0] e;
      m = s[23] ? 14'(-s[23:10]) : s[23:10];
      if (m > 14'd8158) m = 14'd8158;
      m = m + 14'd33;
      e = 3'd0;
      for (int i = 6; i < 13; i++) begin
         if (m[i]) e = 3'(i - 5);
      end
      mu_enc = ~{s[23], e, 4'(m >> (e + 1))};
   endfunction

   // 13-bit magnitude to A-law, A of 87.6 segments
   function automatic logic [7:0] a_enc(input logic [23:0] s);
      logic [12:0] m;
      logic [2:0] e;
      m = s[23] ? 13'(-s[23:11]) : s[23:11];
      if (m > 13'd4095) m = 13'd4095;
      e = 3'd0;
      for (int i = 5; i < 12; i++) begin
         if (m[i]) e = 3'(i - 4);
      end
      a_enc = {~s[23], e, 4'((e == 3'd0) ? (m >> 1) : (m >> e))} ^ 8'h55;
   endfunction

   // received 8-bit code back to a 16-bit sample
   function automatic logic [15:0] law_dec(input logic [7:0] c, input logic alaw);
      logic [7:0] u;
      logic [15:0] m;
      u = alaw ? (c ^ 8'h55) : ~c;
      if (alaw) begin
         m = (u[6:4] == 3'd0) ? {8'h0, u[3:0], 4'h8}
             : ({8'h0, u[3:0], 4'h0} + 16'd264) << (u[6:4] - 3'd1);
      end else begin
         m = (({9'h0, u[3:0], 3'h0} + 16'd132) << u[6:4]) - 16'd132;
      end
      law_dec = (alaw ? u[7] : ~u[7]) ? m : 16'(-m);
   endfunction

   // register bus decode
   wire aw_hit = (aw_addr <= ADDR_STAT) && (aw_addr[1:0] == 2'b00);
   wire ar_hit = (s_axi_araddr <= ADDR_STAT) && (s_axi_araddr[1:0] == 2'b00);
   wire do_write = aw_got && w_got && !s_axi_bvalid;
   wire [31:0] stat = {1'b0, peak[22:16], 1'b0, g_cur, att != ATT_IDLE, 1'b0, depth, hp_gain};
   wire [31:0] rd_word = (s_axi_araddr == ADDR_CTRL) ? ctrl
                       : (s_axi_araddr == ADDR_VOL) ? vol
                       : (s_axi_araddr == ADDR_TIME) ? timing
                       : (s_axi_araddr == ADDR_KNEE) ? knee
                       : (s_axi_araddr == ADDR_SLOPE) ? slope
                       : (s_axi_araddr == ADDR_STAT) ? stat : 32'h0;
   wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

   // applies byte lanes of the held write to one register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] mk);
      merge = (old & ~mk) | (nw & mk);
   endfunction

   // address and data taken in either order, one response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_hit ? 2'b00 : 2'b10; // unmapped answers slave error
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // register storage; status is read only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RST;
         vol <= VOL_RST;
         timing <= TIME_RST;
         knee <= KNEE_RST;
         slope <= SLOPE_RST;
      end else if (do_write) begin
         if (aw_addr == ADDR_CTRL) ctrl <= merge(ctrl, w_data, wmask);
         if (aw_addr == ADDR_VOL) vol <= merge(vol, w_data, wmask);
         if (aw_addr == ADDR_TIME) timing <= merge(timing, w_data, wmask);
         if (aw_addr == ADDR_KNEE) knee <= merge(knee, w_data, wmask);
         if (aw_addr == ADDR_SLOPE) slope <= merge(slope, w_data, wmask);
      end
   end

   // one read at a time, data held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= ar_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // receive side: optional expansion of the low byte, then widen
   wire cen = ctrl[C_CEN];
   wire alaw = ctrl[C_ALAW];
   wire [15:0] in_l = cen ? law_dec(left_playback_channel[7:0], alaw) : left_playback_channel;
   wire [15:0] in_r = cen ? law_dec(right_playback_channel[7:0], alaw) : right_playback_channel;
   wire [23:0] wide_l = {in_l, 8'h00};
   wire [23:0] wide_r = {in_r, 8'h00};
   // digital volume with individual mutes
   wire [23:0] g_l = ctrl[C_MUTE_L] ? 24'h0 : vol_apply(wide_l, vcur_l);
   wire [23:0] g_r = ctrl[C_MUTE_R] ? 24'h0 : vol_apply(wide_r, vcur_r);

   // mixer: bits are serial left, serial right, capture left, capture right
   wire [3:0] mix_l = ctrl[C_MIX_L+:4];
   wire [3:0] mix_r = ctrl[C_MIX_R+:4];
   wire signed [35:0] src0 = 36'(signed'(g_l));
   wire signed [35:0] src1 = 36'(signed'(g_r));
   wire signed [35:0] src2 = 36'(signed'(capture_left));
   wire signed [35:0] src3 = 36'(signed'(capture_right));
   wire [23:0] mx_l = sat24((mix_l[0] ? src0 : 36'sh0) + (mix_l[1] ? src1 : 36'sh0)
                    + (mix_l[2] ? src2 : 36'sh0) + (mix_l[3] ? src3 : 36'sh0));
   wire [23:0] mx_r = sat24((mix_r[0] ? src0 : 36'sh0) + (mix_r[1] ? src1 : 36'sh0)
                    + (mix_r[2] ? src2 : 36'sh0) + (mix_r[3] ? src3 : 36'sh0));

   // peak level of the louder channel after the mixer
   wire [22:0] mag_l = mx_l[23] ? 23'(~mx_l[22:0]) : mx_l[22:0];
   wire [22:0] mag_r = mx_r[23] ? 23'(~mx_r[22:0]) : mx_r[22:0];
   wire [22:0] mag = (mag_l > mag_r) ? mag_l : mag_r;
   wire [2:0] pk_a = timing[T_PKA+3] ? 3'd7 : timing[T_PKA+:3]; // codes past 0111 clamp
   wire [2:0] pk_d = timing[T_PKD+3] ? 3'd7 : timing[T_PKD+:3];
   wire [22:0] pk_up = peak + ((mag - peak) >> (4'(pk_a) + 4'd1)) + 23'd1;
   wire [22:0] pk_dn = peak - (peak >> (4'd6 + pk_d));
   wire [22:0] next_peak = (mag > peak) ? ((pk_up > mag) ? mag : pk_up) : pk_dn;

   // static curve in dB below full scale, 6 dB per leading zero
   wire [7:0] lvl = 8'(lzc(peak)) * 8'd6;
   wire [7:0] kn_lim = {3'b0, knee[K_LIM+:5]};
   wire [7:0] kn_c1 = {3'b0, knee[K_C1+:5]};
   wire [7:0] kn_c2 = {2'b0, knee[K_C2+:6]};
   wire [7:0] kn_str = {2'b0, knee[K_STR+:6]} + STR_KNEE0;
   wire [7:0] kn_gate = {2'b0, knee[K_GATE+:6]} + GATE_KNEE0;
   wire [7:0] d_lim = (lvl < kn_lim) ? kn_lim - lvl : 8'h0;
   wire [7:0] d_c1 = (lvl < kn_c1) ? kn_c1 - lvl : 8'h0;
   wire [7:0] d_c2 = (lvl < kn_c2) ? kn_c2 - lvl : 8'h0;
   wire [7:0] d_str = (lvl > kn_str) ? lvl - kn_str : 8'h0;
   wire [7:0] d_gate = (lvl > kn_gate) ? lvl - kn_gate : 8'h0;
   wire [11:0] g_sum = {4'h0, red(d_lim, slope[S_LIM+:3], 3'd7)}
                     + {4'h0, red(d_c1, slope[S_C1+:3], 3'd5)}
                     + {4'h0, red(d_c2, slope[S_C2+:3], 3'd5)}
                     + {2'b0, stretch(d_str, slope[S_STR+:2])}
                     + {2'b0, stretch(d_gate, slope[S_GATE+:2])};
   wire [6:0] g_raw = (g_sum > 12'd127) ? 7'd127 : g_sum[6:0];
   wire [7:0] g_avg = ({1'b0, g_raw} + {1'b0, g_prev}) >> 1;
   wire [6:0] g_tgt = ctrl[C_SMOOTH] ? g_avg[6:0] : g_raw;
   // gain step periods in samples
   wire [3:0] ga = (timing[T_GA+:4] > 4'hc) ? 4'hc : timing[T_GA+:4];
   wire [3:0] gd = (timing[T_GD+:4] > 4'ha) ? 4'ha : timing[T_GD+:4];
   wire [16:0] atk_len = (17'd2 << ga) - 17'd1;
   wire [16:0] dcy_len = (17'd64 << gd) - 17'd1;
   wire g_step = (g_tgt > g_cur) ? (g_tick + 17'd1 >= atk_len) : (g_tick + 17'd1 >= dcy_len);
   // range control is the last stage before polarity
   wire [4:0] g_sh = (g_cur / 7'd6 > 7'd23) ? 5'd23 : 5'(g_cur / 7'd6);
   wire [23:0] dr_l = 24'($signed(mx_l) >>> g_sh);
   wire [23:0] dr_r = 24'($signed(mx_r) >>> g_sh);
   wire inv = ctrl[C_INV];
   wire [23:0] pol_l = inv ? sat24(-36'(signed'(dr_l))) : dr_l;
   wire [23:0] pol_r = inv ? sat24(-36'(signed'(dr_r))) : dr_r;

   // gain smoothing and peak tracking, per sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         peak <= 23'h0;
         g_cur <= 7'd0;
         g_prev <= 7'd0;
         g_tick <= 17'd0;
      end else if (sample_strobe) begin
         peak <= next_peak;
         g_prev <= g_tgt;
         if (g_tgt == g_cur) g_tick <= 17'd0;
         else if (g_step) begin
            g_tick <= 17'd0;
            g_cur <= (g_tgt > g_cur) ? g_cur + 7'd1 : g_cur - 7'd1;
         end else g_tick <= g_tick + 17'd1;
      end
   end

   // soft mute walks the volume one half-dB per sample
   wire [7:0] vt_l = ctrl[C_SOFT] ? 8'h00 : vol[V_L+:8];
   wire [7:0] vt_r = ctrl[C_SOFT] ? 8'h00 : vol[V_R+:8];
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vcur_l <= VOL_RST[V_L+:8];
         vcur_r <= VOL_RST[V_R+:8];
      end else if (sample_strobe) begin
         if (vcur_l > vt_l) vcur_l <= vcur_l - 8'd1;
         else if (vcur_l < vt_l) vcur_l <= vcur_l + 8'd1;
         if (vcur_r > vt_r) vcur_r <= vcur_r - 8'd1;
         else if (vcur_r < vt_r) vcur_r <= vcur_r + 8'd1;
      end
   end

   // zero detection on the incoming stream, both channels
   wire nonzero = (left_playback_channel != '0) || (right_playback_channel != '0);
   always_ff @(posedge aclk) begin
      if (!aresetn) zrun <= 11'd0;
      else if (sample_strobe) begin
         if (nonzero) zrun <= 11'd0;
         else if (zrun != ZERO_RUN) zrun <= zrun + 11'd1;
      end
   end

   // pop-free driver attenuation; a nonzero sample drops auto demand at once
   wire want = ctrl[C_MAN] || (ctrl[C_AUTO] && (zrun == ZERO_RUN));
   wire [1:0] rsel = ctrl[C_RINT+:2];
   wire [7:0] up_len = (rsel == 2'd0) ? 8'd1 : (rsel == 2'd1) ? 8'd16
                     : (rsel == 2'd2) ? 8'd32 : ATT_STEP;
   wire [7:0] a_next = a_tick + 8'd1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         att <= ATT_IDLE;
         saved <= 8'h00;
         depth <= 6'd0;
         a_tick <= 8'd0;
      end else begin
         case (att)
            ATT_IDLE: begin
               if (want) begin
                  saved <= vol[V_HP+:8];
                  depth <= 6'd0;
                  a_tick <= 8'd0;
                  att <= ATT_DOWN;
               end
            end
            ATT_DOWN: begin
               if (!want) begin
                  a_tick <= 8'd0;
                  att <= ATT_UP; // continue from current depth
               end else if (sample_strobe) begin
                  if (a_next == ATT_STEP) begin
                     a_tick <= 8'd0;
                     depth <= depth + 6'd1;
                     if (depth + 6'd1 == ATT_MAX) att <= ATT_HOLD;
                  end else a_tick <= a_next;
               end
            end
            ATT_HOLD: begin
               if (!want) begin
                  a_tick <= 8'd0;
                  att <= ATT_UP;
               end
            end
            ATT_UP: begin
               if (want) begin
                  a_tick <= 8'd0;
                  att <= ATT_DOWN;
               end else if (depth == 6'd0) att <= ATT_IDLE;
               else if (sample_strobe) begin
                  if (a_next >= up_len) begin
                     a_tick <= 8'd0;
                     depth <= depth - 6'd1;
                     if (depth == 6'd1) att <= ATT_IDLE;
                  end else a_tick <= a_next;
               end
            end
            default: att <= ATT_IDLE;
         endcase
      end
   end

   // registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_left <= 24'h0;
         out_right <= 24'h0;
         out_valid <= 1'b0;
         comp_code <= 8'h00;
         osr_sel <= CTRL_RST[C_OSR+:2];
         hp_gain <= 8'h00;
      end else begin
         out_valid <= sample_strobe;
         osr_sel <= ctrl[C_OSR+:2];
         hp_gain <= (att == ATT_IDLE) ? vol[V_HP+:8] : saved - {2'b0, depth};
         if (sample_strobe) begin
            out_left <= pol_l;
            out_right <= pol_r;
            comp_code <= alaw ? a_enc(pol_l) : mu_enc(pol_l);
         end
      end
   end
endmodule // pdp_playback_path
`default_nettype wire

// ---- pdp_playback_path_assertions.sv ----
// port timing checks of the playback path
`timescale 1ns/10ps
`default_nettype none
module pdp_playback_path_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sample_strobe,
   input wire logic out_valid,
   input wire logic [23:0] out_left,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // one clock domain, so one default clocking and reset
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_ov; sample_strobe |=> out_valid; endproperty
   a_ov: assert property (p_ov) else $error("out_valid missing");
   property p_nov; !sample_strobe |=> !out_valid; endproperty
   a_nov: assert property (p_nov) else $error("stray out_valid");
   property p_hold; !sample_strobe |=> $stable(out_left); endproperty
   a_hold: assert property (p_hold) else $error("sample moved off strobe");
   property p_b; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_b: assert property (p_b) else $error("write response late");
   property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bh: assert property (p_bh) else $error("write response dropped");
   property p_aw; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_aw: assert property (p_aw) else $error("write taken while busy");
   property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready; endproperty
   a_r: assert property (p_r) else $error("read answer late");
   property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rh: assert property (p_rh) else $error("read answer dropped");
endmodule // pdp_playback_path_assertions
bind pdp_playback_path pdp_playback_path_assertions chk_u (.*);
`default_nettype wire

// ---- pdp_serial_source.sv ----
// serial interface model handing playback sample pairs on a strobe
`timescale 1ns/10ps
`default_nettype none
module pdp_serial_source (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] period,
   input wire logic [15:0] l_in,
   input wire logic [15:0] r_in,
   output logic sample_strobe,
   output logic [15:0] left_playback_channel,
   output logic [15:0] right_playback_channel
);
   logic [7:0] cnt; // cycles since the last sample
   wire fire = aresetn && cnt == period; // a sample slot opens
   // 16-bit pairs, junk between slots so stale data is not trusted
   always_ff @(posedge aclk) begin
      cnt <= fire || !aresetn ? 8'h00 : cnt + 8'h01;
      sample_strobe <= fire;
      left_playback_channel <= fire ? l_in : ~left_playback_channel;
      right_playback_channel <= fire ? r_in : ~right_playback_channel;
   end
endmodule // pdp_serial_source
`default_nettype wire

// ---- pdp_playback_path_tb.sv ----
// self-checking bench of the playback path
`timescale 1ns/10ps
`default_nettype none
module pdp_playback_path_tb;
   import pdp_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, out_valid, sample_strobe;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, comp_code, hp_gain, period = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, osr_sel, rsp;
   logic [15:0] left_playback_channel, right_playback_channel, l_in = '0, r_in = '0;
   logic [23:0] capture_left = '0, capture_right = '0, out_left, out_right;
   int failures = 0, n_compared = 0, cyc = 0;
   pdp_serial_source src_u (.*);
   pdp_playback_path dut_u (.*);
   initial forever #12.5 aclk = ~aclk;
   // hang guard
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end
   task end_of_test;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b0;
         if (s_axi_bvalid) rsp = s_axi_bresp;
      end while (s_axi_bready);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b0;
         if (s_axi_rvalid) {rsp, rdat} = {s_axi_rresp, s_axi_rdata};
      end while (s_axi_rready);
   endtask
   // wait for n strobes carrying the pair, then let outputs settle
   task automatic run(input int n, input logic [15:0] l, input logic [15:0] r);
      l_in <= l;
      r_in <= r;
      repeat (n) begin
         @(posedge aclk);
         while (!sample_strobe) @(posedge aclk);
      end
      #1;
   endtask
   task automatic t_regs;
      rd(ADDR_CTRL);
      chk(osr_sel, 32'h3);
      chk(rdat, CTRL_RST);
      rd(ADDR_VOL);
      chk(rdat, VOL_RST);
      rd(8'h40);
      chk(rsp, 32'h2);
      wr(8'h40, 32'hffff_ffff);
      chk(rsp, 32'h2);
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_CTRL, CTRL_RST & 32'hffff_fffc | i);
         repeat (2) @(posedge aclk);
         chk(osr_sel, i);
      end
   endtask
   task automatic t_path;
      period <= 8'h03;
      run(3, 16'h1000, 16'h1000);
      chk(out_left, 32'h10_0000);
      wr(ADDR_CTRL, CTRL_RST | 32'h4);
      run(3, 16'h1000, 16'h1000);
      chk(out_left, 32'hf0_0000);
      wr(ADDR_CTRL, CTRL_RST | 32'h8);
      run(3, 16'h1000, 16'h1000);
      chk(out_left, 32'h0);
      chk(out_right, 32'h10_0000);
      wr(ADDR_CTRL, 32'h0084_0003);
      capture_left <= 24'h12_3456;
      run(3, 16'h1000, 16'h1000);
      chk(out_left, 32'h12_3456);
      wr(ADDR_CTRL, CTRL_RST | 32'h20);
      period <= '0;
      run(300, 16'h1000, 16'h1000);
      chk(out_left, 32'h0);
      wr(ADDR_CTRL, CTRL_RST);
      run(300, 16'h1000, 16'h1000);
      chk(out_left, 32'h10_0000);
      wr(ADDR_KNEE, 32'h12);
      wr(ADDR_SLOPE, SLOPE_RST & 32'hffff_fff8);
      run(100, 16'h1800, 16'h1800);
      chk(out_left, 32'h0c_0000);
      wr(ADDR_SLOPE, SLOPE_RST);
   endtask
   // 8-bit codes in the low byte expand, the output is compressed again
   task automatic t_law;
      wr(ADDR_CTRL, CTRL_RST | 32'h400);
      run(3, 16'h00ef, 16'h00ef);
      chk(out_left, 32'h00_8400);
      chk(comp_code, 32'hef);
      wr(ADDR_CTRL, CTRL_RST | 32'hc00);
      run(3, 16'h00c5, 16'h00c5);
      chk(out_left, 32'h01_0800);
      chk(comp_code, 32'hc5);
   endtask
   task automatic t_att;
      wr(ADDR_VOL, VOL_RST | 32'h40_0000);
      wr(ADDR_CTRL, CTRL_RST | 32'h40);
      run(1000, '0, '0);
      run(2, 16'h1, '0);
      run(1000, '0, '0);
      chk(hp_gain, 32'h40);
      run(100, '0, '0);
      chk(hp_gain, 32'h40);
      run(100, '0, '0);
      chk(hp_gain, 32'h3f);
      run(6800, '0, '0);
      chk(hp_gain, 32'h0a);
      rd(ADDR_STAT);
      chk(rdat, 32'h0000_b60a);
      run(100, 16'h5, 16'h5);
      chk(hp_gain, 32'h40);
      wr(ADDR_CTRL, CTRL_RST | 32'h380);
      run(200, 16'h5, 16'h5);
      chk(hp_gain, 32'h3f);
      wr(ADDR_CTRL, CTRL_RST | 32'h300);
      run(60, 16'h5, 16'h5);
      chk(hp_gain, 32'h3f);
      run(100, 16'h5, 16'h5);
      chk(hp_gain, 32'h40);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_path();
      t_att();
      t_law();
      end_of_test();
   end
endmodule // pdp_playback_path_tb
`default_nettype wire
